// [rtl/hop_pkg.sv]
// shared constants for the channel hop sequencer
// assumes a single 20 MHz system clock domain
package hop_pkg;
    // ==========================================================
    // channel plan
    localparam int         NUM_CHANNELS  = 50;           // hop channels
    localparam int         CHAN_W        = 6;            // channel number width
    localparam logic [5:0] LAST_INDEX    = 6'h31;        // highest index, 49
    localparam logic [6:0] CHAN_COUNT7   = 7'h32;        // 50, for index wrap
    localparam int         BASE_FREQ_KHZ = 912500;       // carrier of channel 0
    localparam int         SPACING_KHZ   = 100;          // step per channel
    // ==========================================================
    // timing
    localparam int          CLK_HZ       = 20000000;     // system clock rate
    localparam int          MS_CYCLES    = CLK_HZ / 1000; // clocks per millisecond
    localparam int          DWELL_MAX_MS = 400;          // dwell budget per window
    localparam logic [8:0]  DWELL_LIMIT  = 9'(DWELL_MAX_MS);
    localparam int          WINDOW_MS    = 20000;        // observation window
    localparam logic [14:0] WINDOW_LAST  = 15'(WINDOW_MS - 1);
    // ==========================================================
    // generator
    localparam int          LFSR_W       = 16;           // generator width
    localparam logic [5:0]  SYNC_FILL    = 6'h03;        // clocks to fill the strap stages
    localparam logic [15:0] LFSR_TAPS    = 16'hB400;     // galois feedback taps
    localparam logic [15:0] LFSR_ALT     = 16'h0001;     // used for an all-zero seed
    // ==========================================================
    // sequencer states
    typedef enum logic [1:0] {
        ST_SEED,
        ST_GEN,
        ST_RUN
    } seq_state_e;
endpackage

// [rtl/hop_lfsr.sv]
// seeded galois shift register giving channel numbers 0..49
// assumes load and step come from logic on the same clock
`timescale 1ns/10ps
`default_nettype none
module hop_lfsr (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        resetn,
    // control
    input  wire logic        load,
    input  wire logic [31:0] seed,
    input  wire logic        step,
    // result
    output logic      [5:0]  value
);
    // ==========================================================
    // state
    typedef struct packed {
        logic [15:0] lfsr;   // generator register
    } lfsr_s;

    lfsr_s st_r;             // registered state
    lfsr_s st_nxt;           // next state
    logic [15:0] folded;     // seed folded to generator width

    // fold the serial-derived seed, never let it be zero
    always_comb begin
        folded = seed[31:16] ^ seed[15:0];
        st_nxt = st_r;
        if (load) begin
            st_nxt.lfsr = (folded == 16'h0000) ? hop_pkg::LFSR_ALT : folded;
        end else if (step) begin
            st_nxt.lfsr = {1'b0, st_r.lfsr[15:1]} ^
                          (st_r.lfsr[0] ? hop_pkg::LFSR_TAPS : 16'h0000);
        end
    end

    // state register
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // reduce to the channel range
    assign value = 6'(st_r.lfsr % 16'(hop_pkg::NUM_CHANNELS));
endmodule
`default_nettype wire

// [rtl/uhf_hop_channel_sequencer.sv]
// frequency hopping channel sequencer for the reader transmit path
// assumes cwOn and txActive come from logic on clk; serialNumber is a static pin strap
// How it works
// - fifty channels 0..49, 100 kHz apart
// - boot builds random order seeded by serial
// - table filled in generation order
// - output channel sets carrier 912.5+0.1*n MHz
// - each carrier switch-on after table build steps index, loads channel
// - index 49 wraps to 0
// - flag timeout past 400 ms per 20 s
// - timeout jumps to next channel under budget
`timescale 1ns/10ps
`default_nettype none
module uhf_hop_channel_sequencer #(
    parameter int CYCLES_PER_MS = hop_pkg::MS_CYCLES   // shorten for simulation
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        resetn,
    // reader serial number strap
    input  wire logic [31:0] serialNumber,
    // carrier control from the protocol engine
    input  wire logic        cwOn,
    input  wire logic        txActive,
    // synthesizer side
    output logic      [5:0]  channelNumber,
    output logic             channelValid,
    // status
    output logic      [5:0]  hopIndex,
    output logic             tableReady,
    output logic             dwellTimeout,
    output logic             allExhausted
);
    // ==========================================================
    // state
    typedef struct packed {
        hop_pkg::seq_state_e     state;     // boot / generate / run
        logic [31:0]             sn1;       // strap synchroniser stage 1
        logic [31:0]             sn2;       // stage 2
        logic [31:0]             sn3;       // stage 3
        logic [5:0]              genCount;  // next table entry to fill
        logic [49:0][5:0]        chanTable; // channel order table
        logic [5:0]              hopIdx;    // hop index
        logic [5:0]              chan;      // current channel number
        logic                    chanValid; // channel may be used
        logic [14:0]             msCount;   // millisecond prescaler
        logic [49:0][8:0]        dwell;     // dwell per channel, ms
        logic [49:0][14:0]       winTime;   // window age per channel, ms
        logic [49:0]             winOn;     // window running per channel
        logic                    timeout;   // dwell timeout pulse
        logic                    exhausted; // no channel left under budget
        logic                    ready;     // table built, run state
    } seq_s;

    seq_s        st_r;         // registered state
    seq_s        st_nxt;       // next state
    logic [5:0]  lfsrValue;    // generator output
    logic        lfsrLoad;     // load seed
    logic        lfsrStep;     // advance generator
    logic        msTick;       // one pulse per millisecond

    // ==========================================================
    // generator
    hop_lfsr u_lfsr (
        .clk    (clk),
        .resetn (resetn),
        .load   (lfsrLoad),
        .seed   (st_r.sn3),
        .step   (lfsrStep),
        .value  (lfsrValue)
    );

    // ==========================================================
    // next state
    always_comb begin
        logic [6:0] cand;      // candidate index during search
        logic [5:0] nextIdx;   // index after a plain advance
        logic       found;     // search hit
        logic [5:0] foundIdx;  // search result
        cand     = 7'h00;
        found    = 1'b0;
        foundIdx = 6'h00;
        st_nxt   = st_r;
        lfsrLoad = 1'b0;
        lfsrStep = 1'b0;
        msTick   = (st_r.msCount == 15'(CYCLES_PER_MS - 1));
        nextIdx  = (st_r.hopIdx == hop_pkg::LAST_INDEX) ? 6'h00 : st_r.hopIdx + 6'h01;
        // strap synchroniser, stage 1 only feeds stage 2
        st_nxt.sn1     = serialNumber;
        st_nxt.sn2     = st_r.sn1;
        st_nxt.sn3     = st_r.sn2;
        st_nxt.timeout = 1'b0;
        // millisecond time base
        st_nxt.msCount = msTick ? 15'h0000 : st_r.msCount + 15'h0001;
        unique case (st_r.state)
            // wait for a settled serial number, then seed
            hop_pkg::ST_SEED: begin
                if (st_r.genCount != hop_pkg::SYNC_FILL) begin
                    // stages 2 and 3 still hold reset zeros: they agree but are no seed
                    st_nxt.genCount = st_r.genCount + 6'h01;
                end else if (st_r.sn2 == st_r.sn3) begin
                    lfsrLoad        = 1'b1;
                    st_nxt.genCount = 6'h00;
                    st_nxt.state    = hop_pkg::ST_GEN;
                end
            end
            // one table entry per clock, first value into entry 0
            hop_pkg::ST_GEN: begin
                st_nxt.chanTable[st_r.genCount] = lfsrValue;
                lfsrStep = 1'b1;
                st_nxt.genCount = st_r.genCount + 6'h01;
                if (st_r.genCount == hop_pkg::LAST_INDEX) begin
                    st_nxt.state  = hop_pkg::ST_RUN;
                    st_nxt.ready  = 1'b1;
                    st_nxt.hopIdx = hop_pkg::LAST_INDEX; // first switch-on lands on entry 0
                end
            end
            // hop and account dwell
            hop_pkg::ST_RUN: begin
                // per-channel window and dwell bookkeeping
                for (int c = 0; c < hop_pkg::NUM_CHANNELS; c++) begin
                    if (msTick && st_r.winOn[c]) begin
                        if (st_r.winTime[c] == hop_pkg::WINDOW_LAST) begin
                            st_nxt.winOn[c]   = 1'b0;
                            st_nxt.winTime[c] = 15'h0000;
                            st_nxt.dwell[c]   = 9'h000;
                        end else begin
                            st_nxt.winTime[c] = st_r.winTime[c] + 15'h0001;
                            if (txActive && st_r.chanValid && st_r.chan == 6'(c) &&
                                st_r.dwell[c] <= hop_pkg::DWELL_LIMIT) begin
                                st_nxt.dwell[c] = st_r.dwell[c] + 9'h001;
                            end
                        end
                    end
                end
                // next index whose channel is still under budget
                for (int k = 1; k <= hop_pkg::NUM_CHANNELS; k++) begin
                    cand = 7'(st_r.hopIdx) + 7'(k);
                    if (cand >= hop_pkg::CHAN_COUNT7) begin
                        cand = cand - hop_pkg::CHAN_COUNT7;
                    end
                    if (!found && st_r.dwell[st_r.chanTable[cand[5:0]]] < hop_pkg::DWELL_LIMIT) begin
                        found    = 1'b1;
                        foundIdx = cand[5:0];
                    end
                end
                if (cwOn) begin
                    // switch-on takes priority over a timeout in the same cycle
                    st_nxt.hopIdx    = nextIdx;
                    st_nxt.chan      = st_r.chanTable[nextIdx];
                    st_nxt.chanValid = 1'b1;
                    st_nxt.exhausted = 1'b0;
                    if (!st_r.winOn[st_r.chanTable[nextIdx]]) begin
                        st_nxt.winOn[st_r.chanTable[nextIdx]]   = 1'b1;
                        st_nxt.winTime[st_r.chanTable[nextIdx]] = 15'h0000;
                    end
                end else if (st_r.chanValid && st_r.dwell[st_r.chan] > hop_pkg::DWELL_LIMIT) begin
                    st_nxt.timeout = 1'b1;
                    if (found) begin
                        st_nxt.hopIdx = foundIdx;
                        st_nxt.chan   = st_r.chanTable[foundIdx];
                        if (!st_r.winOn[st_r.chanTable[foundIdx]]) begin
                            st_nxt.winOn[st_r.chanTable[foundIdx]]   = 1'b1;
                            st_nxt.winTime[st_r.chanTable[foundIdx]] = 15'h0000;
                        end
                    end else begin
                        // nothing left: stop until the next switch-on
                        st_nxt.chanValid = 1'b0;
                        st_nxt.exhausted = 1'b1;
                    end
                end
            end
        endcase
    end

    // state register
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from the state register
    assign channelNumber = st_r.chan;
    assign channelValid  = st_r.chanValid;
    assign hopIndex      = st_r.hopIdx;
    assign tableReady    = st_r.ready;
    assign dwellTimeout  = st_r.timeout;
    assign allExhausted  = st_r.exhausted;

    // ==========================================================
    // checks
    logic tableBad;   // some table entry out of range
    always_comb begin
        tableBad = 1'b0;
        for (int e = 0; e < hop_pkg::NUM_CHANNELS; e++) begin
            if (st_r.chanTable[e] > hop_pkg::LAST_INDEX) begin
                tableBad = 1'b1;
            end
        end
    end

    chan_range_a: assert property (@(posedge clk) disable iff (!resetn)
        st_r.chanValid |-> st_r.chan <= hop_pkg::LAST_INDEX)
        else $error("channel number out of range");
    table_range_a: assert property (@(posedge clk) disable iff (!resetn)
        tableReady |-> !tableBad)
        else $error("table holds an out-of-range channel");
    gen_order_a: assert property (@(posedge clk) disable iff (!resetn)
        st_r.state == hop_pkg::ST_GEN |=>
        st_r.chanTable[$past(st_r.genCount)] == $past(lfsrValue))
        else $error("table entry not the generated value");
    hop_load_a: assert property (@(posedge clk) disable iff (!resetn)
        (tableReady && cwOn) |=> channelValid && channelNumber == st_r.chanTable[hopIndex])
        else $error("channel does not match table entry");
    hop_step_a: assert property (@(posedge clk) disable iff (!resetn)
        (tableReady && cwOn && hopIndex != hop_pkg::LAST_INDEX) |=> hopIndex == $past(hopIndex) + 6'h01)
        else $error("hop index did not step by one");
    hop_wrap_a: assert property (@(posedge clk) disable iff (!resetn)
        (tableReady && cwOn && hopIndex == hop_pkg::LAST_INDEX) |=> hopIndex == 6'h00)
        else $error("hop index did not wrap");
    dwell_flag_a: assert property (@(posedge clk) disable iff (!resetn)
        (tableReady && !cwOn && channelValid && st_r.dwell[st_r.chan] > hop_pkg::DWELL_LIMIT)
        |=> dwellTimeout ##1 !dwellTimeout)
        else $error("dwell overrun not flagged once");
    skip_target_a: assert property (@(posedge clk) disable iff (!resetn)
        (dwellTimeout && channelValid) |-> st_r.dwell[st_r.chan] < hop_pkg::DWELL_LIMIT)
        else $error("timeout hopped to an exhausted channel");
    window_clear_a: assert property (@(posedge clk) disable iff (!resetn)
        (tableReady && msTick && st_r.winOn[st_r.chan] && st_r.winTime[st_r.chan] == hop_pkg::WINDOW_LAST)
        |=> st_r.dwell[$past(st_r.chan)] == 9'h000)
        else $error("window expiry left dwell uncleared");
    ms_base_a: assert property (@(posedge clk) disable iff (!resetn)
        msTick |=> st_r.msCount == 15'h0000 ##1 st_r.msCount == 15'h0001)
        else $error("millisecond counter misbehaves");

    table_done_c: cover property (@(posedge clk) disable iff (!resetn) $rose(tableReady));
    wrap_seen_c:  cover property (@(posedge clk) disable iff (!resetn)
        cwOn && hopIndex == hop_pkg::LAST_INDEX && tableReady);
    timeout_c:    cover property (@(posedge clk) disable iff (!resetn) dwellTimeout);
    exhausted_c:  cover property (@(posedge clk) disable iff (!resetn) $rose(allExhausted));
endmodule
`default_nettype wire

// [verification/pll_synth_model.sv]
// synthesizer model: turns the selected channel into a carrier in kHz
// assumes channelNumber and channelValid are registers on the same clock
`timescale 1ns/10ps
`default_nettype none
module pll_synth_model (
    // clock
    input  wire logic       clk,
    // selected channel from the sequencer
    input  wire logic [5:0] channelNumber,
    input  wire logic       channelValid,
    // tuned carrier
    output int              freqKhz,
    output logic            chanBad
);
    // ==========================================================
    // tuning
    // retunes one edge after the channel, like a loop settling
    always @(posedge clk) begin
        if (channelValid === 1'b1) begin
            // carrier from channel number
            freqKhz <= hop_pkg::BASE_FREQ_KHZ + hop_pkg::SPACING_KHZ * int'(channelNumber);
            chanBad <= (channelNumber > 6'h31);
        end else begin
            // no channel: carrier parked
            freqKhz <= 0;
            chanBad <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// [verification/uhf_hop_channel_sequencer_test.sv]
// bench for the channel hop sequencer: table walk, wrap, dwell skip, window expiry
// assumes the design under rtl/ and the synthesizer model beside this file
`timescale 1ns/10ps
`default_nettype none
module uhf_hop_channel_sequencer_test;
    // ==========================================================
    // signals and model state
    localparam int CPM = 2;            // clocks per ms tick, shortened
    logic        clk;                  // system clock
    logic        resetn;               // async reset, active low
    logic [31:0] serialNumber;         // serial strap
    logic        cwOn;                 // switch-on pulse
    logic        txActive;             // carrier on
    logic [5:0]  channelNumber;        // channel to synthesizer
    logic        channelValid;         // channel usable
    logic [5:0]  hopIndex;             // current index
    logic        tableReady;           // table built
    logic        dwellTimeout;         // timeout pulse
    logic        allExhausted;         // no channel left
    int          freqKhz;              // synthesizer carrier
    logic        chanBad;              // synthesizer out of band
    int          nErrors;              // mismatches
    int          totalChecks;          // comparisons
    int          tbl [50];             // model channel order table
    int          dwellM [50];          // model dwell per channel, ms
    int          idx;                  // model hop index
    int          n;                    // wait counter
    int          lf;                   // model generator register
    bit          learn;                // first pass also range checks each channel
    // ==========================================================
    // design and partner
    uhf_hop_channel_sequencer #(.CYCLES_PER_MS(CPM)) uhf_hop_channel_sequencer_inst (
        .clk(clk), .resetn(resetn), .serialNumber(serialNumber), .cwOn(cwOn),
        .txActive(txActive), .channelNumber(channelNumber), .channelValid(channelValid),
        .hopIndex(hopIndex), .tableReady(tableReady), .dwellTimeout(dwellTimeout),
        .allExhausted(allExhausted));
    pll_synth_model pll_synth_model_inst (
        .clk(clk), .channelNumber(channelNumber), .channelValid(channelValid),
        .freqKhz(freqKhz), .chanBad(chanBad));
    // ==========================================================
    // clock
    initial clk = 1'b0;
    always #25 clk = ~clk;
    // ==========================================================
    // helpers
    // one comparison, reported at once
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        totalChecks++;
        if (got !== exp) begin
            nErrors++;
            $display("unexpected %s: expected %0d, seen %0d", what, exp, got);
        end
    endtask
    // verdict and end of run
    task automatic finishTest();
        $display("checks %0d, errors %0d", totalChecks, nErrors);
        if (nErrors == 0 && totalChecks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // one switch-on pulse, then compare with the model
    task automatic hop();
        cwOn = 1'b1;
        @(negedge clk);
        cwOn = 1'b0;
        @(negedge clk);
        idx = (idx == 49) ? 0 : idx + 1;
        if (learn) begin
            // first pass: every channel also range checked
            chk("channelRange", 1, channelNumber < 6'h32);
        end
        chk("hopIndex", idx, hopIndex);
        chk("channelNumber", tbl[idx], channelNumber);
        chk("channelValid", 1, channelValid);
        chk("allExhausted", 0, allExhausted);
        chk("carrierKhz", 912500 + 100 * tbl[idx], freqKhz);
        chk("inBand", 0, chanBad);
    endtask
    // carrier on until a timeout, then compare the skip target
    task automatic dwell();
        int k;
        k = 0;
        txActive = 1'b1;
        while (dwellTimeout !== 1'b1 && k < 401 * CPM + 10) begin
            @(negedge clk);
            k++;
        end
        chk("dwellSpanOk", 1, k >= 400 * CPM && k < 401 * CPM + 10);
        dwellM[tbl[idx]] = 401;
        // next index still under budget
        do idx = (idx + 1) % 50; while (dwellM[tbl[idx]] >= 400);
        chk("skipIndex", idx, hopIndex);
        chk("skipChannel", tbl[idx], channelNumber);
        @(negedge clk);
        chk("timeoutPulse", 0, dwellTimeout);
    endtask
    // ==========================================================
    // main sequence
    initial begin
        void'($urandom(38713));
        cwOn = 1'b0;
        txActive = 1'b0;
        resetn = 1'b0;
        serialNumber = $urandom();
        nErrors = 0;
        totalChecks = 0;
        idx = 49;
        learn = 1'b1;
        foreach (dwellM[i]) dwellM[i] = 0;
        // model table: folded serial seed, galois steps, reduced to 0..49
        lf = int'(serialNumber[31:16] ^ serialNumber[15:0]);
        if (lf == 0) lf = int'(hop_pkg::LFSR_ALT);
        for (int e = 0; e < 50; e++) begin
            tbl[e] = lf % 50;
            lf = (lf >> 1) ^ ((lf % 2 == 1) ? int'(hop_pkg::LFSR_TAPS) : 0);
        end
        repeat (3) @(negedge clk);
        chk("resetValid", 0, channelValid);
        chk("resetReady", 0, tableReady);
        resetn = 1'b1;
        // early switch-on must be ignored
        @(negedge clk);
        cwOn = 1'b1;
        @(negedge clk);
        cwOn = 1'b0;
        n = 0;
        while (tableReady !== 1'b1 && n < 200) begin
            @(negedge clk);
            n++;
        end
        chk("tableReady", 1, tableReady);
        chk("earlyValid", 0, channelValid);
        chk("startIndex", 49, hopIndex);
        // first pass also range checks channels, second compares the table with random gaps
        repeat (50) hop();
        learn = 1'b0;
        repeat (50) begin
            repeat ($urandom_range(0, 2)) @(negedge clk);
            hop();
        end
        // three timeouts in a row from index 0
        hop();
        repeat (3) dwell();
        txActive = 1'b0;
        // idle past every window, model dwell cleared
        repeat (20000 * CPM + 200) @(negedge clk);
        foreach (dwellM[i]) dwellM[i] = 0;
        while (idx != 0) hop();
        dwell();
        finishTest();
    end
    // ==========================================================
    // watchdog
    initial begin
        repeat (60000) @(posedge clk);
        nErrors++;
        $display("unexpected watchdog: expected end of tests, seen hang");
        finishTest();
    end
endmodule
`default_nettype wire
